// ==== src/jts_tap.sv ====
// Purpose: test access port: tap controller, instruction register, bypass stage, serial output
// Assumes: test clock far slower than clk_sys (80 ns against 10 ns)
// Notes:   test clock edges are found by sampling; outputs follow by a few clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
`include "jts_consts.svh"
module jts_tap #(
    parameter int IR_W = `JTS_IR_WIDTH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire jts_pkg::jts_link_in_t link_in,
    output var  jts_pkg::jts_link_out_t link_out,
    output var  logic [IR_W-1:0]       active_ir,
    output var  logic                  bypass_sel,
    output var  jts_pkg::jts_state_t   tap_state
);
    // -----------------------------------------------------------------
    // reset release and input synchronisation
    // -----------------------------------------------------------------
    logic                  rst_a_reg;
    logic                  rst_n;
    jts_pkg::jts_link_in_t pins;
    logic                  tck_prev_reg;
    logic                  tck_rise;
    logic                  tck_fall;
    logic [2:0]            arm_cnt_reg;
    logic                  armed;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_a_reg <= 1'b0;
            rst_n     <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_n     <= rst_a_reg;
        end
    end

    jts_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (link_in),
        .dout    (pins)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tck_prev_reg <= 1'b0;
        end
        else
        begin
            tck_prev_reg <= pins.tck;
        end
    end

    // the synchroniser resets low while the idle test clock stands high; edges stay
    // masked until real pin levels have come through, or reset would fake a rise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arm_cnt_reg <= 3'h0;
        end
        else if (arm_cnt_reg != `JTS_ARM_CYCLES)
        begin
            arm_cnt_reg <= arm_cnt_reg + 3'h1;
        end
    end

    assign armed    = (arm_cnt_reg == `JTS_ARM_CYCLES);
    assign tck_rise = armed & pins.tck & ~tck_prev_reg;
    assign tck_fall = armed & ~pins.tck & tck_prev_reg;

    // -----------------------------------------------------------------
    // tap controller
    // -----------------------------------------------------------------
    jts_pkg::jts_state_t state_reg;
    jts_pkg::jts_state_t state_next;

    // mode select is trusted to be stable at rising edges
    function automatic jts_pkg::jts_state_t jts_step(input jts_pkg::jts_state_t s, input logic m);
        case (s)
            jts_pkg::JTS_TLR:  jts_step = m ? jts_pkg::JTS_TLR  : jts_pkg::JTS_RTI;
            jts_pkg::JTS_RTI:  jts_step = m ? jts_pkg::JTS_SDR  : jts_pkg::JTS_RTI;
            jts_pkg::JTS_SDR:  jts_step = m ? jts_pkg::JTS_SIR  : jts_pkg::JTS_CDR;
            jts_pkg::JTS_CDR:  jts_step = m ? jts_pkg::JTS_E1DR : jts_pkg::JTS_SHDR;
            jts_pkg::JTS_SHDR: jts_step = m ? jts_pkg::JTS_E1DR : jts_pkg::JTS_SHDR;
            jts_pkg::JTS_E1DR: jts_step = m ? jts_pkg::JTS_UDR  : jts_pkg::JTS_PDR;
            jts_pkg::JTS_PDR:  jts_step = m ? jts_pkg::JTS_E2DR : jts_pkg::JTS_PDR;
            jts_pkg::JTS_E2DR: jts_step = m ? jts_pkg::JTS_UDR  : jts_pkg::JTS_SHDR;
            jts_pkg::JTS_UDR:  jts_step = m ? jts_pkg::JTS_SDR  : jts_pkg::JTS_RTI;
            jts_pkg::JTS_SIR:  jts_step = m ? jts_pkg::JTS_TLR  : jts_pkg::JTS_CIR;
            jts_pkg::JTS_CIR:  jts_step = m ? jts_pkg::JTS_E1IR : jts_pkg::JTS_SHIR;
            jts_pkg::JTS_SHIR: jts_step = m ? jts_pkg::JTS_E1IR : jts_pkg::JTS_SHIR;
            jts_pkg::JTS_E1IR: jts_step = m ? jts_pkg::JTS_UIR  : jts_pkg::JTS_PIR;
            jts_pkg::JTS_PIR:  jts_step = m ? jts_pkg::JTS_E2IR : jts_pkg::JTS_PIR;
            jts_pkg::JTS_E2IR: jts_step = m ? jts_pkg::JTS_UIR  : jts_pkg::JTS_SHIR;
            jts_pkg::JTS_UIR:  jts_step = m ? jts_pkg::JTS_SDR  : jts_pkg::JTS_RTI;
            default:           jts_step = jts_pkg::JTS_TLR;
        endcase
    endfunction : jts_step

    assign state_next = jts_step(state_reg, pins.tms);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= jts_pkg::JTS_TLR;
        end
        else if (tck_rise)
        begin
            state_reg <= state_next;
        end
    end

    // -----------------------------------------------------------------
    // instruction register
    // -----------------------------------------------------------------
    logic [IR_W-1:0] ir_shift_reg;
    logic [IR_W-1:0] ir_active_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_shift_reg <= IR_W'(`JTS_IR_CAPTURE);
        end
        else if (tck_rise)
        begin
            if (state_reg == jts_pkg::JTS_CIR)
            begin
                ir_shift_reg <= IR_W'(`JTS_IR_CAPTURE);
            end
            else if (state_reg == jts_pkg::JTS_SHIR)
            begin
                // lsb leaves first, new bit enters at msb; last shift on exit edge
                ir_shift_reg <= {pins.tdi, ir_shift_reg[IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ir_active_reg <= IR_W'(`JTS_IR_RESET);
        end
        else if (tck_fall && state_reg == jts_pkg::JTS_TLR)
        begin
            ir_active_reg <= IR_W'(`JTS_IR_RESET);
        end
        else if (tck_fall && state_reg == jts_pkg::JTS_UIR)
        begin
            ir_active_reg <= ir_shift_reg;
        end
    end

    logic is_bypass;
    // unknown codes also fall back to bypass; no other data register exists here
    assign is_bypass = (ir_active_reg == IR_W'(`JTS_IR_BYPASS)) || 1'b1;

    // -----------------------------------------------------------------
    // bypass stage and data-register parallel stage
    // -----------------------------------------------------------------
    logic bypass_reg;
    logic bypass_upd_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bypass_reg <= 1'b0;
        end
        else if (tck_rise && is_bypass)
        begin
            if (state_reg == jts_pkg::JTS_CDR)
            begin
                bypass_reg <= 1'b0;
            end
            else if (state_reg == jts_pkg::JTS_SHDR)
            begin
                bypass_reg <= pins.tdi;
            end
        end
    end

    // bypass has no real parallel stage; this holds the last shifted bit
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bypass_upd_reg <= 1'b0;
        end
        else if (tck_fall && state_reg == jts_pkg::JTS_UDR)
        begin
            bypass_upd_reg <= bypass_reg;
        end
    end

    // -----------------------------------------------------------------
    // serial output, changes on falling edges only
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_out <= '0;
        end
        else if (tck_fall)
        begin
            case (state_reg)
                jts_pkg::JTS_CIR, jts_pkg::JTS_SHIR:
                begin
                    link_out.tdo_oe <= 1'b1;
                    link_out.tdo    <= ir_shift_reg[0];
                end
                jts_pkg::JTS_CDR, jts_pkg::JTS_SHDR:
                begin
                    link_out.tdo_oe <= 1'b1;
                    link_out.tdo    <= bypass_reg;
                end
                jts_pkg::JTS_E1IR, jts_pkg::JTS_PIR, jts_pkg::JTS_E2IR,
                jts_pkg::JTS_E1DR, jts_pkg::JTS_PDR, jts_pkg::JTS_E2DR:
                begin
                    link_out.tdo_oe <= link_out.tdo_oe;
                end
                default:
                begin
                    link_out.tdo_oe <= 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // status outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_ir  <= IR_W'(`JTS_IR_RESET);
            bypass_sel <= 1'b1;
            tap_state  <= jts_pkg::JTS_TLR;
        end
        else
        begin
            active_ir  <= ir_active_reg;
            bypass_sel <= is_bypass;
            tap_state  <= state_reg;
        end
    end

    logic unused_upd;
    assign unused_upd = bypass_upd_reg;
endmodule : jts_tap
`default_nettype wire

// ==== src/jts_consts.svh ====
// Purpose: constants of the scan test access port
// Assumes: included by bare name
// Notes:   definitions only
`ifndef JTS_CONSTS_SVH
`define JTS_CONSTS_SVH
`define JTS_IR_WIDTH      8
`define JTS_IR_CAPTURE    8'h81
`define JTS_IR_BYPASS     8'hFF
`define JTS_IR_RESET      8'hFF
`define JTS_SYNC_STAGES   3
`define JTS_ARM_CYCLES    3'h7
`endif

// ==== src/jts_pkg.sv ====
// Purpose: types of the scan test access port
// Assumes: nothing
// Notes:   state codes are one-hot
package jts_pkg;
    typedef enum logic [15:0] {
        JTS_TLR  = 16'h0001,
        JTS_RTI  = 16'h0002,
        JTS_SDR  = 16'h0004,
        JTS_CDR  = 16'h0008,
        JTS_SHDR = 16'h0010,
        JTS_E1DR = 16'h0020,
        JTS_PDR  = 16'h0040,
        JTS_E2DR = 16'h0080,
        JTS_UDR  = 16'h0100,
        JTS_SIR  = 16'h0200,
        JTS_CIR  = 16'h0400,
        JTS_SHIR = 16'h0800,
        JTS_E1IR = 16'h1000,
        JTS_PIR  = 16'h2000,
        JTS_E2IR = 16'h4000,
        JTS_UIR  = 16'h8000
    } jts_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jts_link_in_t;

    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jts_link_out_t;
endpackage : jts_pkg

// ==== src/jts_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input asynchronous to clk_sys
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
`default_nettype none
module jts_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            dout   <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a change counts only once stages two and three agree
            for (int i = 0; i < WIDTH; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : jts_sync
`default_nettype wire

// ==== tb/jts_tap_checker.sv ====
// Purpose: port assertions for the scan test access port
// Assumes: test clock far slower than clk_sys
// Notes:   ages count clk_sys cycles since a seen test-clock edge
`timescale 1ns/1ps
`default_nettype none
module jts_tap_checker #(
    parameter int IR_W = 8
) (
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire jts_pkg::jts_link_in_t  link_in,
    input wire jts_pkg::jts_link_out_t link_out,
    input wire logic [IR_W-1:0]        active_ir,
    input wire logic                   bypass_sel,
    input wire jts_pkg::jts_state_t    tap_state
);
    logic       tck_reg;
    logic [3:0] rise_reg;
    logic [3:0] fall_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tck_reg  <= 1'b1;
            rise_reg <= 4'hF;
            fall_reg <= 4'hF;
        end
        else
        begin
            tck_reg  <= link_in.tck;
            rise_reg <= (link_in.tck && !tck_reg) ? 4'h0 : rise_reg + {3'h0, rise_reg != 4'hF};
            fall_reg <= (!link_in.tck && tck_reg) ? 4'h0 : fall_reg + {3'h0, fall_reg != 4'hF};
        end
    end
    a_state_onehot: assert property ($onehot(tap_state))
        else $error("state not one-hot");
    a_bypass_held: assert property (bypass_sel)
        else $error("bypass not selected");
    a_oe_rise: assert property ($rose(link_out.tdo_oe) |-> tap_state inside {jts_pkg::JTS_CIR, jts_pkg::JTS_CDR})
        else $error("output enabled outside capture");
    a_oe_hold: assert property ($rose(link_out.tdo_oe) |=> link_out.tdo_oe [*6])
        else $error("output enable dropped early");
    a_oe_fall: assert property ($fell(link_out.tdo_oe) |-> tap_state inside {jts_pkg::JTS_UIR, jts_pkg::JTS_UDR})
        else $error("output floated outside update");
    a_ir_load: assert property (!$stable(active_ir) |-> tap_state inside {jts_pkg::JTS_UIR, jts_pkg::JTS_TLR})
        else $error("instruction changed outside update");
    a_idle_entry: assert property ($changed(tap_state) && $past(tap_state) == jts_pkg::JTS_TLR
        |-> tap_state == jts_pkg::JTS_RTI)
        else $error("bad exit from reset state");
    a_shir_exit: assert property ($changed(tap_state) && $past(tap_state) == jts_pkg::JTS_SHIR
        |-> tap_state == jts_pkg::JTS_E1IR)
        else $error("bad exit from shift-ir");
    a_state_time: assert property ($changed(tap_state) |-> rise_reg inside {[3:7]})
        else $error("state moved off a rising edge");
    a_oe_time: assert property ($changed(link_out.tdo_oe) |-> fall_reg inside {[3:7]})
        else $error("enable moved off a falling edge");
endmodule : jts_tap_checker
bind jts_tap jts_tap_checker #(.IR_W(IR_W)) u_chk (.clk_sys(clk_sys), .nrst(nrst), .link_in(link_in),
    .link_out(link_out), .active_ir(active_ir), .bypass_sel(bypass_sel), .tap_state(tap_state));
`default_nettype wire

// ==== tb/jts_host.sv ====
// Purpose: scan test controller model driving the test port
// Assumes: 80 ns test clock built from clk_sys falling edges
// Notes:   test clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module jts_host (
    input wire logic                   clk_sys,
    input wire jts_pkg::jts_link_out_t link_out,
    output var jts_pkg::jts_link_in_t  link_in
);
    logic s_oe  = 1'b0;
    logic s_tdo = 1'b0;
    event smp;
    initial link_in = 3'h7;
    // read just before the falling edge, when the last update has settled
    task automatic sample();
        s_oe  = link_out.tdo_oe;
        s_tdo = link_out.tdo_oe ? link_out.tdo : !s_tdo;
    endtask : sample
    task automatic cyc(input logic tms, input logic tdi);
        @(negedge clk_sys);
        sample();
        link_in.tck = 1'b0;
        link_in.tms = tms;
        link_in.tdi = tdi;
        repeat (4) @(negedge clk_sys);
        -> smp;
        link_in.tck = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : cyc
    task automatic settle();
        repeat (8) @(negedge clk_sys);
        sample();
        -> smp;
    endtask : settle
endmodule : jts_host
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the scan test access port
// Assumes: one checked sample per test-clock cycle
// Notes:   bench keeps its own tap model as state indices
`timescale 1ns/1ps
`default_nettype none
`include "jts_consts.svh"
module testbench;
    typedef struct packed {
        logic [15:0] st;
        logic        oe;
        logic        tv;
        logic        tdo;
        logic [7:0]  act;
    } jts_exp_t;
    logic                   clk_sys    = 1'b0;
    logic                   nrst       = 1'b0;
    jts_pkg::jts_link_in_t  link_in;
    jts_pkg::jts_link_out_t link_out;
    logic [7:0]             active_ir;
    logic                   bypass_sel;
    jts_pkg::jts_state_t    tap_state;
    jts_exp_t               exp_q[$];
    jts_exp_t               e;
    int                     err_count  = 0;
    int                     n_compared = 0;
    int                     seed       = 32'hBF76571D;
    int                     ci         = 0;
    logic [7:0]             m_sh       = 8'hFF;
    logic [7:0]             m_act      = 8'hFF;
    logic                   m_byp      = 1'b0;
    logic                   m_oe       = 1'b0;
    int                     n0[16]     = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
    int                     n1[16]     = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
    always #5 clk_sys = ~clk_sys;
    jts_tap #(.IR_W(8)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .link_in(link_in), .link_out(link_out),
        .active_ir(active_ir), .bypass_sel(bypass_sel), .tap_state(tap_state));
    jts_host u_host (.clk_sys(clk_sys), .link_out(link_out), .link_in(link_in));
    task automatic cmp(input string nm, input logic [15:0] exp_v, input logic [15:0] got);
        n_compared++;
        if (got !== exp_v)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp_v, got);
        end
    endtask : cmp
    task automatic chk_state(input logic [15:0] exp_v, input logic [15:0] got);
        cmp("tap_state", exp_v, got);
    endtask : chk_state
    task automatic chk_oe(input logic exp_v, input logic got);
        cmp("tdo_oe", {15'h0, exp_v}, {15'h0, got});
    endtask : chk_oe
    task automatic chk_tdo(input logic exp_v, input logic got);
        cmp("tdo", {15'h0, exp_v}, {15'h0, got});
    endtask : chk_tdo
    task automatic chk_ir(input logic [7:0] exp_v, input logic [7:0] got);
        cmp("active_ir", {8'h0, exp_v}, {8'h0, got});
    endtask : chk_ir
    task automatic chk_byp(input logic exp_v, input logic got);
        cmp("bypass_sel", {15'h0, exp_v}, {15'h0, got});
    endtask : chk_byp
    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // falling-edge effects in the current state, then the rising-edge move
    task automatic step(input logic tms, input logic tdi);
        jts_exp_t x;
        x.tv  = (ci == 4) || (ci == 11);
        x.tdo = (ci == 11) ? m_sh[0] : m_byp;
        if (ci == 3 || ci == 10) m_oe = 1'b1;
        if (ci == 8 || ci == 15) m_oe = 1'b0;
        if (ci == 15) m_act = m_sh;
        if (ci == 0) m_act = 8'hFF;
        u_host.cyc(tms, tdi);
        if (ci == 10) m_sh = `JTS_IR_CAPTURE;
        if (ci == 11) m_sh = {tdi, m_sh[7:1]};
        if (ci == 3) m_byp = 1'b0;
        if (ci == 4) m_byp = tdi;
        ci = tms ? n1[ci] : n0[ci];
        x.st  = 16'h1 << ci;
        x.oe  = m_oe;
        x.act = m_act;
        exp_q.push_back(x);
    endtask : step
    task automatic seq(input logic [31:0] tms, input logic [31:0] tdi, input int n);
        for (int i = 0; i < n; i++)
            step(tms[i], tdi[i]);
    endtask : seq
    // each sample belongs to the cycle before it
    always @(u_host.smp)
    begin
        if (exp_q.size() != 0)
        begin
            e = exp_q.pop_front();
            chk_state(e.st, tap_state);
            chk_oe(e.oe, u_host.s_oe);
            if (e.tv) chk_tdo(e.tdo, u_host.s_tdo);
            chk_ir(e.act, active_ir);
            chk_byp(1'b1, bypass_sel);
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        repeat (10) @(negedge clk_sys);
        seq(32'h00F87006, 32'h000A1FE0, 24);
        u_host.settle();
        for (int i = 0; i < 400; i++)
            step(1'($random(seed)), 1'($random(seed)));
        u_host.settle();
        // reset in mid-run, mode select left wherever the random walk put it
        nrst = 1'b0;
        repeat (3) @(negedge clk_sys);
        nrst  = 1'b1;
        ci    = 0;
        m_oe  = 1'b0;
        m_act = `JTS_IR_RESET;
        repeat (10) @(negedge clk_sys);
        chk_state(16'h1, tap_state);
        chk_oe(1'b0, link_out.tdo_oe);
        chk_tdo(1'b0, link_out.tdo);
        chk_ir(`JTS_IR_RESET, active_ir);
        chk_byp(1'b1, bypass_sel);
        seq(32'h1F, 32'h0, 5);
        seq(32'h00F87006, 32'h000A1FE0, 24);
        u_host.settle();
        end_of_test();
    end
    initial
    begin
        #100000;
        err_count++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
